// ---- rtl/bkr_pkg.sv ----
package bkr_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] LEVEL_OFS = 8'h10;
  localparam logic [7:0] MODE_OFS  = 8'h11;
  localparam logic [7:0] RSVD_OFS  = 8'h12;
  localparam logic [7:0] ENPG_OFS  = 8'h13;
  // field positions
  localparam int LEVEL_CODE_MSB = 5;
  localparam int RANGE_BIT      = 6;
  localparam int MODE_BIT       = 0;
  localparam int ENABLE_BIT     = 0;
  localparam int PGOOD_BIT      = 1;
  localparam int EXACT_BIT      = 2;
  // reset values of writable fields (arbitrary plain defaults)
  localparam logic [5:0] LEVEL_CODE_RST = 6'h00;
  localparam logic       RANGE_RST      = 1'b1;
  localparam logic       MODE_RST       = 1'b0;
  localparam logic       ENABLE_RST     = 1'b0;
  localparam logic       EXACT_RST      = 1'b0;
  // read-only bits, value may vary per part (arbitrary)
  localparam logic [7:0] RO_LEVEL_RST = 8'h00;
  localparam logic [7:0] RO_MODE_RST  = 8'h00;
  localparam logic [7:0] RO_RSVD_RST  = 8'h00;
  localparam logic [7:0] RO_ENPG_RST  = 8'h00;
  // voltage decode in millivolts
  localparam logic [12:0] HIGH_BASE_MV = 13'd1250;
  localparam logic [12:0] HIGH_STEP_MV = 13'd50;
  localparam logic [12:0] LOW_BASE_MV  = 13'd1100;
  localparam logic [12:0] LOW_STEP_MV  = 13'd25;
  localparam logic [5:0]  LOW_FIRST    = 6'h12;
endpackage

// ---- rtl/bkr_low_rom.sv ----
`timescale 1ns/1ns
// low range level table, registered read data
module bkr_low_rom (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic [5:0]  i_code,
  output logic      [12:0] o_mv,
  output logic             o_valid
);
  logic [12:0] next_mv;  // combinational table value
  logic        next_ok;  // code available

  // table of millivolt values, zero where unavailable
  always_comb begin
    next_ok = (i_code >= 6'h12);
    unique case (i_code[5:4])
      2'b01: next_mv = 13'd1100 + 13'd25 * {9'h000, i_code[3:0] - 4'h2}
                       + ((i_code[3:0] >= 4'h8) ? 13'd5 : 13'd0);
      2'b10: next_mv = 13'd1455 + 13'd25 * {9'h000, i_code[3:0]}
                       + ((i_code[3:0] >= 4'h5) ? 13'd5 : 13'd0);
      2'b11: next_mv = 13'd1860 + 13'd25 * {9'h000, i_code[3:0]}
                       + ((i_code[3:0] >= 4'h1) ? 13'd5 : 13'd0)
                       - ((i_code[3:0] >= 4'he) ? 13'd15 : 13'd0)
                       + ((i_code[3:0] == 4'hf) ? 13'd20 : 13'd0);
      default: next_mv = 13'd0;
    endcase
    if (!next_ok) begin
      next_mv = 13'd0;
    end
  end

  // registered output of the table
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mv    <= 13'd0;
      o_valid <= 1'b0;
    end else if (i_ce) begin
      o_mv    <= next_mv;
      o_valid <= next_ok;
    end
  end
endmodule

// ---- rtl/bkr_regs.sv ----
`timescale 1ns/1ns
// Operation
// [RULE1] six-bit level code at 0x10 bits 5:0
// [RULE2] bit six selects low or high range
// [RULE3] listed bits read-only with part values
// [RULE4] 0x11 bit zero forces pulse-width mode
// [RULE5] 0x13 bit zero enables the converter
// [RULE6] 0x13 bit one reads power-good
// [RULE7] software writes write-exact bit exactly
// [RULE8] high range 1.250V plus 50mV steps
// [RULE9] low range skips codes, 1.100 to 2.245V
// [RULE10] single-byte register reads and writes
// [RULE11] read-only bits and power-good ignore writes
// [RULE12] software avoids unavailable low codes
module bkr_regs
  import bkr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_power_good,
  output logic      [7:0]  o_rdata,
  output logic             o_rvalid,
  output logic      [5:0]  o_output_level_code,
  output logic             o_level_range_select,
  output logic             o_forced_pwm,
  output logic             o_regulator_enable,
  output logic             o_exact_bit,
  output logic      [12:0] o_nominal_mv,
  output logic             o_code_valid
);
  import bkr_pkg::*;

  logic [5:0]  output_level_code;   // level code field
  logic        level_range_select;  // range select field
  logic        auto_pulse_mode_n;   // one forces pulse-width
  logic        enable;              // converter enable
  logic        exact;               // write-exact bit store
  logic        pgood;               // sampled monitor flag
  logic [7:0]  next_rdata;          // read mux value
  logic [12:0] low_mv;              // low range table value
  logic        low_ok;              // low code available
  logic        range_q;             // range aligned with table
  logic [12:0] high_mv;             // high range value

  // level and range fields
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      output_level_code  <= LEVEL_CODE_RST;
      level_range_select <= RANGE_RST;
    end else if (i_ce && i_wr && i_addr == LEVEL_OFS) begin  // [RULE10]
      output_level_code  <= i_wdata[LEVEL_CODE_MSB:0];        // [RULE1]
      level_range_select <= i_wdata[RANGE_BIT];               // [RULE2]
    end
  end

  // mode field
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      auto_pulse_mode_n <= MODE_RST;
    end else if (i_ce && i_wr && i_addr == MODE_OFS) begin
      auto_pulse_mode_n <= i_wdata[MODE_BIT];  // [RULE4]
    end
  end

  // enable and write-exact; power-good never written
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      enable <= ENABLE_RST;
      exact  <= EXACT_RST;
    end else if (i_ce && i_wr && i_addr == ENPG_OFS) begin
      enable <= i_wdata[ENABLE_BIT];  // [RULE5]
      exact  <= i_wdata[EXACT_BIT];   // [RULE7]
    end
  end

  // power-good follows the output monitor only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pgood <= 1'b0;
    end else if (i_ce) begin
      pgood <= i_power_good;  // [RULE6] [RULE11]
    end
  end

  // read mux; read-only bits show fixed part values
  always_comb begin
    unique case (i_addr)
      LEVEL_OFS: next_rdata = {RO_LEVEL_RST[7], level_range_select,
                               output_level_code};  // [RULE3]
      MODE_OFS:  next_rdata = {RO_MODE_RST[7:1], auto_pulse_mode_n};
      RSVD_OFS:  next_rdata = RO_RSVD_RST;  // [RULE3]
      ENPG_OFS:  next_rdata = {RO_ENPG_RST[7:3], exact, pgood, enable};
      default:   next_rdata = 8'h00;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_rd;  // [RULE10]
      if (i_rd) begin
        o_rdata <= next_rdata;
      end
    end
  end

  // control outputs straight from flops
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_output_level_code  <= LEVEL_CODE_RST;
      o_level_range_select <= RANGE_RST;
      o_forced_pwm         <= MODE_RST;
      o_regulator_enable   <= ENABLE_RST;
      o_exact_bit          <= EXACT_RST;
      range_q              <= RANGE_RST;
    end else if (i_ce) begin
      o_output_level_code  <= output_level_code;
      o_level_range_select <= level_range_select;
      o_forced_pwm         <= auto_pulse_mode_n;
      o_regulator_enable   <= enable;
      o_exact_bit          <= exact;
      range_q              <= level_range_select;
    end
  end

  // low range table lookup
  bkr_low_rom u_low_rom (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_code   (output_level_code),
    .o_mv     (low_mv),
    .o_valid  (low_ok)
  );  // [RULE9]

  // high range linear decode
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      high_mv <= 13'd0;
    end else if (i_ce) begin
      high_mv <= HIGH_BASE_MV
                 + HIGH_STEP_MV * {7'h00, output_level_code};  // [RULE8]
    end
  end

  // nominal voltage pick by range
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_nominal_mv <= 13'd0;
      o_code_valid <= 1'b0;
    end else if (i_ce) begin
      o_nominal_mv <= range_q ? high_mv : low_mv;  // [RULE2]
      o_code_valid <= range_q | low_ok;            // [RULE9]
    end
  end
endmodule

// ---- dv/bkr_regs_chk.sv ----
`timescale 1ns/1ns
// port checks of the register group
module bkr_regs_chk
  import bkr_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_ce,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rvalid,
  input wire logic [5:0] o_output_level_code,
  input wire logic       o_level_range_select,
  input wire logic       o_forced_pwm,
  input wire logic       o_regulator_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_read_answer: assert property (i_ce && i_rd |=> o_rvalid)
    else $error("read not answered");
  chk_no_spurious: assert property (!(i_ce && i_rd) |=> !o_rvalid)
    else $error("answer without read");
  chk_rsvd_zero: assert property (i_ce && i_rd && i_addr == RSVD_OFS
    |=> o_rdata == 8'h00) else $error("reserved byte not zero");
  chk_level_top: assert property (i_ce && i_rd && i_addr == LEVEL_OFS
    |=> !o_rdata[7]) else $error("level top bit not read-only");
  chk_level_write: assert property ((i_ce && i_wr &&
    i_addr == LEVEL_OFS) ##1 i_ce |=> {o_level_range_select,
    o_output_level_code} == $past(i_wdata[6:0], 2))
    else $error("level field not copied");
  chk_mode_write: assert property ((i_ce && i_wr &&
    i_addr == MODE_OFS) ##1 i_ce |=> o_forced_pwm == $past(i_wdata[0], 2))
    else $error("mode bit not copied");
  chk_enable_write: assert property ((i_ce && i_wr &&
    i_addr == ENPG_OFS) ##1 i_ce |=> o_regulator_enable ==
    $past(i_wdata[0], 2)) else $error("enable bit not copied");
  chk_code_hold: assert property (!i_wr [*2] |=>
    $stable(o_output_level_code)) else $error("level moved unwritten");
endmodule
bind bkr_regs bkr_regs_chk u_chk (.*);

// ---- dv/bkr_host_mdl.sv ----
`timescale 1ns/1ns
// byte-level host: one strobe per single-byte access
module bkr_host_mdl (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial o_wr = 0;
  initial o_rd = 0;
  initial o_addr = 8'h00;
  initial o_wdata = 8'h00;
  // one byte write, lines scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask
  // one byte read, answer taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b0, ~a};
    v = i_rvalid;
    d = i_rdata;
  endtask
endmodule

// ---- dv/bkr_regs_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module bkr_regs_tb_top;
  import bkr_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_ce = 1, i_pg = 1, wr, rd, rv, cv;
  logic [7:0] addr, wd, rdat;
  logic [12:0] mv;
  logic [5:0] lc;
  logic rs, fp, en, ex;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #10 i_clk = ~i_clk;
  bkr_host_mdl u_host (.i_clk(i_clk), .i_rdata(rdat), .i_rvalid(rv),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd));
  bkr_regs dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wd), .i_power_good(i_pg),
    .o_rdata(rdat), .o_rvalid(rv), .o_output_level_code(lc),
    .o_level_range_select(rs), .o_forced_pwm(fp), .o_regulator_enable(en),
    .o_exact_bit(ex), .o_nominal_mv(mv), .o_code_valid(cv));
  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // read one byte and compare with the expected value
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask
  // level codes in both ranges, with decoded millivolts
  task automatic t_level;
    logic [7:0] dv[7] = '{8'hc0, 8'hff, 8'h55, 8'h12, 8'h3f, 8'h20, 8'h00};
    logic [12:0] ev[7] = '{1250, 4400, 2300, 1100, 2245, 1455, 0};
    for (int k = 0; k < 7; k++) begin
      u_host.wr(LEVEL_OFS, dv[k]);
      repeat (5) @(negedge i_clk);
      rdchk(LEVEL_OFS, dv[k] & 8'h7f);
      `CHK(mv, ev[k])
      `CHK(cv, (k < 6))
      `CHK({rs, lc}, dv[k][6:0])
    end
  endtask
  // mode, enable, power-good, reserved and unmapped places
  task automatic t_ctrl;
    u_host.wr(MODE_OFS, 8'hff);
    rdchk(MODE_OFS, 8'h01);
    `CHK(fp, 1'b1)
    // write-exact bit kept at its default value
    u_host.wr(ENPG_OFS, 8'hfb);
    rdchk(ENPG_OFS, 8'h03);
    `CHK(en, 1'b1)
    `CHK(ex, EXACT_RST)
    i_pg = 0;
    u_host.wr(ENPG_OFS, 8'h02);
    repeat (2) @(negedge i_clk);
    rdchk(ENPG_OFS, 8'h00);
    `CHK(en, 1'b0)
    u_host.wr(RSVD_OFS, 8'hff);
    rdchk(RSVD_OFS, 8'h00);
    u_host.wr(8'h20, 8'hff);
    rdchk(8'h20, 8'h00);
  endtask
  // clock enable low drops a write; reset in mid-run
  task automatic t_freeze;
    @(negedge i_clk);
    i_ce = 0;
    u_host.wr(LEVEL_OFS, 8'h15);
    @(negedge i_clk);
    i_ce = 1;
    rdchk(LEVEL_OFS, 8'h00);
    i_resetn = 0;
    @(negedge i_clk);
    i_resetn = 1;
    rdchk(LEVEL_OFS, 8'h40);
    `CHK(en, ENABLE_RST)
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(negedge i_clk);
    i_resetn = 1;
    rdchk(LEVEL_OFS, 8'h40);
    rdchk(ENPG_OFS, 8'h02);
    t_level();
    t_ctrl();
    t_freeze();
    end_sim();
  end
endmodule
